// ==== hdl/cam_top.v ====
// cpu integer datapath: alu, multiplier, divider, status and core control
// assumes the decoder presents one operation per opValid pulse and waits
// while busy is high; apb master on the same clk_sys
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "cam_defs.vh"

module cam_top #(
  parameter DATA_W = 16
) (
  // clock, reset, enable
  input  wire              clk_sys,
  input  wire              sys_rst,
  input  wire              clkEn,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // decoder request
  input  wire              opValid,
  input  wire [3:0]        opCode,
  input  wire [2:0]        mulMode,
  input  wire [4:0]        opLiteral,
  input  wire              byteMode,
  input  wire              srcFromMem,
  input  wire              dstToMem,
  input  wire [DATA_W-1:0] wregOperandA,
  input  wire [DATA_W-1:0] wregOperandB,
  input  wire [DATA_W-1:0] memOperand,
  // exception level control
  input  wire              trapLevelSet,
  input  wire              trapLevelClear,
  // results
  output reg  [DATA_W-1:0] resultData,
  output reg  [DATA_W-1:0] resultHigh,
  output reg               wregWrite,
  output reg               memWrite,
  output reg               busy,
  // status outputs
  output reg  [DATA_W-1:0] processor_status_word,
  output reg               priority_level_top_bit,
  output reg               program_space_window_enable,
  output reg               userIntBlock
);

  // decoded apb access
  wire        apbAccess = psel && penable && !pready;
  wire        apbWrite  = apbAccess && pwrite;
  wire        hitCore   = (paddr == `CAM_ADDR_CORE_CTRL);
  wire        hitStatus = (paddr == `CAM_ADDR_STATUS_WORD);
  wire        hitHigh   = (paddr == `CAM_ADDR_RESULT_HIGH);
  wire        hitRem    = (paddr == `CAM_ADDR_DIV_REM);
  wire        hitAny    = hitCore || hitStatus || hitHigh || hitRem;

  // second operand from registers or memory
  wire [15:0] operandB = srcFromMem ? memOperand : wregOperandB;

  wire [15:0] aluResult;
  wire        aluCarry;
  wire        aluNibble;
  wire        aluOvf;
  wire        aluUpdCarry;
  wire        aluUpdArith;
  wire        aluZero;
  wire        aluNeg;
  wire [31:0] product;

  cam_alu uAlu (
    .opA         (wregOperandA),
    .opB         (operandB),
    .opCode      (opCode),
    .byteMode    (byteMode),
    .result      (aluResult),
    .carry       (aluCarry),
    .nibbleCarry (aluNibble),
    .overflow    (aluOvf),
    .updCarry    (aluUpdCarry),
    .updArith    (aluUpdArith),
    .zero        (aluZero),
    .negative    (aluNeg)
  );

  cam_mul uMul (
    .opA     (wregOperandA),
    .opB     (operandB),
    .literal (opLiteral),
    .mode    (mulMode),
    .product (product)
  );

  // divider state: restoring, one quotient bit per cycle
  localparam ST_IDLE = 1'b0;
  localparam ST_DIV  = 1'b1;
  reg         state;
  reg  [4:0]  divCount;
  reg  [15:0] divisor;
  reg  [15:0] quotient;
  reg  [16:0] remainder;
  reg         divDst;
  reg  [15:0] divRem;
  wire [16:0] remShift = {remainder[15:0], quotient[15]};
  wire [16:0] remTrial = remShift - {1'b0, divisor};
  wire [15:0] next_quot = {quotient[14:0], !remTrial[16]};
  wire [16:0] next_rem  = remTrial[16] ? remShift : remTrial;

  wire        startOp  = clkEn && opValid && (state == ST_IDLE);
  wire        isMul    = (opCode == `CAM_OP_MUL);
  wire        isDiv    = (opCode == `CAM_OP_DIV);
  wire        mulByte  = (mulMode == `CAM_MUL_BB);
  wire        divDone  = (state == ST_DIV) && (divCount == 5'h01);

  // hardware flag update for this cycle
  reg  [15:0] next_status;
  always @* begin
    next_status = processor_status_word;
    if (apbWrite && hitStatus) begin
      next_status = pwdata[15:0] & `CAM_SW_MASK;
    end
    // flags per operation, hardware wins over software
    if (startOp && !isMul && !isDiv) begin
      next_status[`CAM_SW_ZERO] = aluZero;
      next_status[`CAM_SW_NEG]  = aluNeg;
      if (aluUpdCarry) begin
        next_status[`CAM_SW_CARRY] = aluCarry;
      end
      if (aluUpdArith) begin
        next_status[`CAM_SW_OVF]    = aluOvf;
        next_status[`CAM_SW_NIBBLE] = aluNibble;
      end
    end
    if (startOp && isMul) begin
      next_status[`CAM_SW_ZERO] = mulByte ? (product[15:0] == 16'h0000)
                                          : (product == 32'h00000000);
    end
    if (divDone) begin
      next_status[`CAM_SW_ZERO] = (next_quot == 16'h0000);
      next_status[`CAM_SW_NEG]  = 1'b0;
    end
  end

  // datapath and divider
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      divCount   <= 5'h00;
      divisor    <= 16'h0000;
      quotient   <= 16'h0000;
      remainder  <= 17'h00000;
      divDst     <= 1'b0;
      divRem     <= 16'h0000;
      resultData <= 16'h0000;
      resultHigh <= 16'h0000;
      wregWrite  <= 1'b0;
      memWrite   <= 1'b0;
      busy       <= 1'b0;
    end else if (clkEn) begin
      wregWrite <= 1'b0;
      memWrite  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (opValid) begin
            if (isDiv) begin
              state     <= ST_DIV;
              divCount  <= `CAM_DIV_STEPS;
              divisor   <= operandB;
              quotient  <= wregOperandA;
              remainder <= 17'h00000;
              divDst    <= dstToMem;
              busy      <= 1'b1;
            end else begin
              wregWrite <= !dstToMem;
              memWrite  <= dstToMem;
              if (isMul) begin
                resultData <= product[15:0];
                resultHigh <= mulByte ? 16'h0000 : product[31:16];
              end else begin
                resultData <= aluResult;
              end
            end
          end
        end
        ST_DIV: begin
          quotient  <= next_quot;
          remainder <= next_rem;
          divCount  <= divCount - 5'h01;
          if (divDone) begin
            state      <= ST_IDLE;
            busy       <= 1'b0;
            resultData <= next_quot;
            divRem     <= next_rem[15:0];
            wregWrite  <= !divDst;
            memWrite   <= divDst;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // status word and core control
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      processor_status_word       <= `CAM_SW_RESET;
      priority_level_top_bit      <= 1'b0;
      program_space_window_enable <= 1'b0;
      userIntBlock                <= 1'b0;
    end else if (clkEn) begin
      // low priority bits live in status word
      processor_status_word <= next_status;
      if (trapLevelSet) begin
        priority_level_top_bit <= 1'b1;
      end else if (trapLevelClear) begin
        priority_level_top_bit <= 1'b0;
      end
      // block user interrupts at top level
      userIntBlock <= trapLevelSet || (priority_level_top_bit && !trapLevelClear);
      if (apbWrite && hitCore) begin
        program_space_window_enable <= pwdata[`CAM_CC_WINDOW];
      end
    end
  end

  // apb answer: one wait state, registered
  reg [15:0] readMux;
  always @* begin
    readMux = 16'h0000;
    if (hitCore) begin
      readMux[`CAM_CC_TOP_BIT] = priority_level_top_bit;
      readMux[`CAM_CC_WINDOW]  = program_space_window_enable;
    end else if (hitStatus) begin
      readMux = processor_status_word;
    end else if (hitHigh) begin
      readMux = resultHigh;
    end else if (hitRem) begin
      readMux = divRem;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready  <= apbAccess;
      pslverr <= apbAccess && !hitAny;
      if (apbAccess && !pwrite) begin
        prdata <= {16'h0000, readMux};
      end
    end
  end

endmodule

// ==== common/cam_defs.vh ====
// constants for the cpu alu / multiplier / core control block
// assumes a 125 MHz clk_sys and an apb master with 32-bit data
`ifndef CAM_DEFS_VH
`define CAM_DEFS_VH

// apb byte addresses
`define CAM_ADDR_CORE_CTRL   8'h00
`define CAM_ADDR_STATUS_WORD 8'h04
`define CAM_ADDR_RESULT_HIGH 8'h08
`define CAM_ADDR_DIV_REM     8'h0c

// core control fields
`define CAM_CC_TOP_BIT   3
`define CAM_CC_WINDOW    2
`define CAM_CC_RESET     16'h0000

// processor status word fields
`define CAM_SW_CARRY     0
`define CAM_SW_ZERO      1
`define CAM_SW_OVF       2
`define CAM_SW_NEG       3
`define CAM_SW_PRI_LO    5
`define CAM_SW_PRI_HI    7
`define CAM_SW_NIBBLE    8
`define CAM_SW_MASK      16'h01ef
`define CAM_SW_RESET     16'h0000

// alu operation codes
`define CAM_OP_ADD  4'h0
`define CAM_OP_SUB  4'h1
`define CAM_OP_AND  4'h2
`define CAM_OP_IOR  4'h3
`define CAM_OP_XOR  4'h4
`define CAM_OP_SHL  4'h5
`define CAM_OP_LSR  4'h6
`define CAM_OP_ASR  4'h7
`define CAM_OP_MUL  4'h8
`define CAM_OP_DIV  4'h9

// multiplier modes
`define CAM_MUL_SS   3'h0
`define CAM_MUL_UU   3'h1
`define CAM_MUL_US   3'h2
`define CAM_MUL_SU   3'h3
`define CAM_MUL_SLIT 3'h4
`define CAM_MUL_ULIT 3'h5
`define CAM_MUL_BB   3'h6

// divider
`define CAM_DIV_STEPS 5'h10

`endif

// ==== hdl/cam_alu.v ====
// combinational 16-bit alu with status flag outputs
// assumes operands are already selected and held stable by the caller
`timescale 1ns/1ps
`include "cam_defs.vh"

module cam_alu (
  // operands
  input  wire [15:0] opA,
  input  wire [15:0] opB,
  input  wire [3:0]  opCode,
  input  wire        byteMode,
  // result and flags
  output reg  [15:0] result,
  output reg         carry,
  output reg         nibbleCarry,
  output reg         overflow,
  output reg         updCarry,
  output reg         updArith,
  output wire        zero,
  output wire        negative
);

  wire [15:0] bInv = (opCode == `CAM_OP_SUB) ? ~opB : opB;
  wire        cin  = (opCode == `CAM_OP_SUB);
  wire [16:0] sumW = {1'b0, opA} + {1'b0, bInv} + {16'h0000, cin};
  wire [8:0]  sumB = {1'b0, opA[7:0]} + {1'b0, bInv[7:0]} + {8'h00, cin};
  wire [4:0]  sumN = {1'b0, opA[3:0]} + {1'b0, bInv[3:0]} + {4'h0, cin};
  wire        msbA = byteMode ? opA[7] : opA[15];
  wire        msbB = byteMode ? bInv[7] : bInv[15];
  wire        msbR = byteMode ? result[7] : result[15];
  // sign of the sum straight from the adder keeps the flag path acyclic
  wire        msbS = byteMode ? sumB[7] : sumW[15];

  assign zero     = byteMode ? (result[7:0] == 8'h00) : (result == 16'h0000);
  assign negative = msbR;

  always @* begin
    result      = 16'h0000;
    carry       = 1'b0;
    nibbleCarry = sumN[4];
    overflow    = 1'b0;
    updCarry    = 1'b0;
    updArith    = 1'b0;
    case (opCode)
      `CAM_OP_ADD, `CAM_OP_SUB: begin
        result   = byteMode ? {8'h00, sumB[7:0]} : sumW[15:0];
        carry    = byteMode ? sumB[8] : sumW[16];
        overflow = (msbA == msbB) && (msbS != msbA);
        updCarry = 1'b1;
        updArith = 1'b1;
      end
      `CAM_OP_AND: result = opA & opB;
      `CAM_OP_IOR: result = opA | opB;
      `CAM_OP_XOR: result = opA ^ opB;
      `CAM_OP_SHL: begin
        result   = {opA[14:0], 1'b0};
        carry    = msbA;
        updCarry = 1'b1;
      end
      `CAM_OP_LSR: begin
        result   = byteMode ? {9'h000, opA[7:1]} : {1'b0, opA[15:1]};
        carry    = opA[0];
        updCarry = 1'b1;
      end
      `CAM_OP_ASR: begin
        result   = byteMode ? {8'h00, opA[7], opA[7:1]} : {opA[15], opA[15:1]};
        carry    = opA[0];
        updCarry = 1'b1;
      end
      default: result = 16'h0000;
    endcase
    // byte ops clear the upper byte
    if (byteMode) begin
      result = {8'h00, result[7:0]};
    end
  end

endmodule

// ==== hdl/cam_mul.v ====
// combinational 17x17 multiplier serving all product modes
// assumes the literal is the five low bits of the instruction
`timescale 1ns/1ps
`include "cam_defs.vh"

module cam_mul (
  // operands
  input  wire [15:0] opA,
  input  wire [15:0] opB,
  input  wire [4:0]  literal,
  input  wire [2:0]  mode,
  // product
  output wire [31:0] product
);

  reg  [16:0] extA;
  reg  [16:0] extB;

  always @* begin
    extA = {1'b0, opA};
    extB = {1'b0, opB};
    case (mode)
      `CAM_MUL_SS: begin
        extA = {opA[15], opA};
        extB = {opB[15], opB};
      end
      `CAM_MUL_US: extB = {opB[15], opB};
      `CAM_MUL_SU: extA = {opA[15], opA};
      `CAM_MUL_SLIT: begin
        extA = {opA[15], opA};
        extB = {12'h000, literal};
      end
      `CAM_MUL_ULIT: extB = {12'h000, literal};
      `CAM_MUL_BB: begin
        extA = {9'h000, opA[7:0]};
        extB = {9'h000, opB[7:0]};
      end
      default: extA = {1'b0, opA};
    endcase
  end

  wire signed [33:0] full = $signed(extA) * $signed(extB);
  assign product = full[31:0];

endmodule

// ==== verification/cam_checker.sv ====
// checker on the datapath top ports
// assumes clkEn held high and no trap pulse during a core control read
`timescale 1ns/1ps
module cam_checker #(
  parameter DATA_W = 16
) (
  // clock and reset
  input wire              clk_sys,
  input wire              sys_rst,
  input wire              clkEn,
  // apb
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [7:0]        paddr,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  // operations
  input wire              opValid,
  input wire [3:0]        opCode,
  input wire              byteMode,
  input wire              dstToMem,
  input wire              trapLevelSet,
  input wire              trapLevelClear,
  input wire [DATA_W-1:0] resultData,
  input wire              wregWrite,
  input wire              memWrite,
  input wire              busy,
  // status
  input wire [DATA_W-1:0] processor_status_word,
  input wire              priority_level_top_bit,
  input wire              program_space_window_enable,
  input wire              userIntBlock
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire take   = opValid && !busy && clkEn;
  wire wr     = psel && penable && pwrite && !pready && clkEn;
  wire done   = wregWrite || memWrite;
  wire winBit = pwdata[2];
  wire aluOp  = take && opCode < 4'h8;

  AST_TOP_SET: assert property (trapLevelSet && clkEn |=> priority_level_top_bit)
    else $error("top bit not set");
  AST_TOP_CLR: assert property (
    trapLevelClear && !trapLevelSet && clkEn |=> !priority_level_top_bit)
    else $error("top bit not cleared");
  AST_INT_BLOCK: assert property (
    userIntBlock == priority_level_top_bit)
    else $error("user interrupt block wrong");
  AST_NO_SW: assert property (
    wr && paddr == 8'h00 && !trapLevelSet && !trapLevelClear
    |=> $stable(priority_level_top_bit)) else $error("top bit written");
  AST_WINDOW: assert property (
    wr && paddr == 8'h00 |=> program_space_window_enable == $past(winBit))
    else $error("window bit not written");
  AST_CC_READ: assert property (pready && !pwrite && paddr == 8'h00 |->
    prdata == {28'h0, priority_level_top_bit, program_space_window_enable, 2'b00})
    else $error("core control read wrong");
  AST_DEST: assert property (take && opCode != 4'h9 |=>
    memWrite == $past(dstToMem) && wregWrite == !$past(dstToMem))
    else $error("result destination wrong");
  AST_DIV_BUSY: assert property (take && opCode == 4'h9 |=> busy [*8])
    else $error("busy not held");
  AST_DIV_DONE: assert property (take && opCode == 4'h9 |-> ##17 done)
    else $error("division result late");
  AST_ZERO: assert property (done && $past(aluOp) |-> processor_status_word[1] ==
    ($past(byteMode) ? resultData[7:0] == 8'h00 : resultData == 16'h0000))
    else $error("zero flag wrong");
  AST_NEG: assert property (done && $past(aluOp) |-> processor_status_word[3] ==
    ($past(byteMode) ? resultData[7] : resultData[15])) else $error("negative flag wrong");
endmodule

// ==== verification/cam_decoder_model.sv ====
// decoder-side model: presents one operation and holds it until taken
// assumes issue is called by the bench from its clocked sequence
`timescale 1ns/1ps
module cam_decoder_model (
  // clock and handshake
  input  wire         clk_sys,
  input  wire         busy,
  // request
  output logic        opValid,
  output logic [3:0]  opCode,
  output logic [2:0]  mulMode,
  output logic [4:0]  opLiteral,
  output logic        byteMode,
  output logic        srcFromMem,
  output logic        dstToMem,
  output logic [15:0] wregOperandA,
  output logic [15:0] wregOperandB,
  output logic [15:0] memOperand
);
  initial begin
    {opValid, opCode, mulMode, opLiteral, byteMode, srcFromMem, dstToMem} = '0;
    {wregOperandA, wregOperandB, memOperand} = '0;
  end
  task automatic issue(input logic [3:0] c, input logic [2:0] m, input logic [4:0] l,
                       input logic bm, sm, dm, input logic [15:0] a, b, mo);
    @(posedge clk_sys);
    {opCode, mulMode, opLiteral, byteMode, srcFromMem, dstToMem} <= {c, m, l, bm, sm, dm};
    {wregOperandA, wregOperandB, memOperand} <= {a, b, mo};
    opValid <= 1'b1;
    do @(posedge clk_sys); while (busy !== 1'b0);
    opValid <= 1'b0;
    // stale operands inverted so a late read never matches
    {wregOperandA, wregOperandB, memOperand} <= ~{a, b, mo};
  endtask
endmodule

// ==== verification/cpu_alu_multiplier_core_control_tb.sv ====
// bench for the datapath top: apb registers, alu, multiplier, divider
// assumes the decoder model and checker files compile first
`timescale 1ns/1ps
`include "cam_defs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module cpu_alu_multiplier_core_control_tb;
  logic        clk_sys, sys_rst, clkEn, psel, penable, pwrite, pready, pslverr, er;
  logic        trapLevelSet, trapLevelClear, opValid, byteMode, srcFromMem, dstToMem;
  logic        wregWrite, memWrite, busy, priority_level_top_bit;
  logic        program_space_window_enable, userIntBlock;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  opCode;
  logic [2:0]  mulMode;
  logic [4:0]  opLiteral;
  logic [15:0] wregOperandA, wregOperandB, memOperand, resultData, resultHigh;
  logic [15:0] processor_status_word;
  int          n_errors, n_compared, cyc;

  cam_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .opValid(opValid), .opCode(opCode),
    .mulMode(mulMode), .opLiteral(opLiteral), .byteMode(byteMode),
    .srcFromMem(srcFromMem), .dstToMem(dstToMem), .wregOperandA(wregOperandA),
    .wregOperandB(wregOperandB), .memOperand(memOperand), .trapLevelSet(trapLevelSet),
    .trapLevelClear(trapLevelClear), .resultData(resultData), .resultHigh(resultHigh),
    .wregWrite(wregWrite), .memWrite(memWrite), .busy(busy),
    .processor_status_word(processor_status_word),
    .priority_level_top_bit(priority_level_top_bit),
    .program_space_window_enable(program_space_window_enable),
    .userIntBlock(userIntBlock));
  cam_decoder_model i_dec (.clk_sys(clk_sys), .busy(busy), .opValid(opValid),
    .opCode(opCode), .mulMode(mulMode), .opLiteral(opLiteral), .byteMode(byteMode),
    .srcFromMem(srcFromMem), .dstToMem(dstToMem), .wregOperandA(wregOperandA),
    .wregOperandB(wregOperandB), .memOperand(memOperand));

  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable, pwdata} <= {2'b00, ~d};
  endtask

  task op(input logic [3:0] c, input logic [2:0] m, input logic bm, sm, dm,
          input logic [15:0] a, b);
    i_dec.issue(c, m, 5'h1f, bm, sm, dm, a, sm ? ~b : b, sm ? b : ~b);
    do @(posedge clk_sys); while (!(wregWrite || memWrite));
  endtask

  task alu(input logic [3:0] c, input logic bm, sm, dm, input logic [15:0] a, b, r, fm, f);
    op(c, 3'h0, bm, sm, dm, a, b);
    `CHK(resultData, r)
    `CHK(processor_status_word & fm, f)
    `CHK({wregWrite, memWrite}, {!dm, dm})
  endtask

  task mul(input logic [2:0] m, input logic [15:0] a, b, input logic [31:0] p);
    op(`CAM_OP_MUL, m, 1'b0, 1'b0, 1'b0, a, b);
    `CHK({resultHigh, resultData}, p)
  endtask

  task t_regs;
    apb(1'b0, `CAM_ADDR_CORE_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, `CAM_ADDR_CORE_CTRL, 32'hffffffff);
    apb(1'b0, `CAM_ADDR_CORE_CTRL, 32'h0);
    `CHK(rd, 32'h4)
    `CHK(program_space_window_enable, 1'b1)
    apb(1'b1, `CAM_ADDR_CORE_CTRL, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    `CHK(program_space_window_enable, 1'b0)
    $display("t_regs done");
  endtask

  task t_level;
    clkEn <= 1'b0;
    trapLevelSet <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(priority_level_top_bit, 1'b0)
    clkEn <= 1'b1;
    @(posedge clk_sys);
    trapLevelSet <= 1'b1;
    @(posedge clk_sys);
    trapLevelSet <= 1'b0;
    @(posedge clk_sys);
    `CHK({priority_level_top_bit, userIntBlock}, 2'b11)
    apb(1'b1, `CAM_ADDR_CORE_CTRL, 32'h0);
    apb(1'b0, `CAM_ADDR_CORE_CTRL, 32'h0);
    `CHK(rd, 32'h8)
    apb(1'b1, `CAM_ADDR_STATUS_WORD, 32'hffff);
    apb(1'b0, `CAM_ADDR_STATUS_WORD, 32'h0);
    `CHK(rd & 32'he0, 32'he0)
    trapLevelClear <= 1'b1;
    @(posedge clk_sys);
    trapLevelClear <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK({priority_level_top_bit, userIntBlock}, 2'b00)
    $display("t_level done");
  endtask

  task t_arith;
    alu(`CAM_OP_ADD, 0, 0, 0, 16'h7fff, 16'h0001, 16'h8000, 16'h10f, 16'h10c);
    alu(`CAM_OP_SUB, 0, 0, 0, 16'h0000, 16'h0001, 16'hffff, 16'h10f, 16'h008);
    alu(`CAM_OP_SUB, 0, 0, 1, 16'h0005, 16'h0003, 16'h0002, 16'h10f, 16'h101);
    alu(`CAM_OP_ADD, 1, 1, 0, 16'h12ff, 16'h0001, 16'h0000, 16'h10f, 16'h103);
    alu(`CAM_OP_AND, 0, 0, 1, 16'hf0f0, 16'h0ff0, 16'h00f0, 16'h00a, 16'h000);
    alu(`CAM_OP_IOR, 0, 0, 0, 16'h8000, 16'h0001, 16'h8001, 16'h00a, 16'h008);
    alu(`CAM_OP_XOR, 0, 1, 0, 16'haaaa, 16'haaaa, 16'h0000, 16'h00a, 16'h002);
    alu(`CAM_OP_SHL, 0, 0, 0, 16'h8001, 16'h0001, 16'h0002, 16'h00b, 16'h001);
    alu(`CAM_OP_LSR, 0, 0, 0, 16'h8001, 16'h0001, 16'h4000, 16'h00b, 16'h001);
    alu(`CAM_OP_ASR, 0, 0, 0, 16'h8001, 16'h0001, 16'hc000, 16'h00b, 16'h009);
    $display("t_arith done");
  endtask

  task t_mul;
    mul(`CAM_MUL_SS, 16'hffff, 16'hffff, 32'h00000001);
    mul(`CAM_MUL_UU, 16'hffff, 16'hffff, 32'hfffe0001);
    mul(`CAM_MUL_US, 16'hffff, 16'hffff, 32'hffff0001);
    mul(`CAM_MUL_SU, 16'hffff, 16'hffff, 32'hffff0001);
    mul(`CAM_MUL_SLIT, 16'hfffe, 16'h0003, 32'hffffffc2);
    mul(`CAM_MUL_ULIT, 16'hfffe, 16'h0003, 32'h001effc2);
    mul(`CAM_MUL_BB, 16'hffff, 16'hffff, 32'h0000fe01);
    $display("t_mul done");
  endtask

  task t_div;
    op(`CAM_OP_DIV, 3'h0, 1'b0, 1'b0, 1'b0, 16'h0064, 16'h0007);
    `CHK(resultData, 16'h000e)
    apb(1'b0, `CAM_ADDR_DIV_REM, 32'h0);
    `CHK(rd, 32'h2)
    op(`CAM_OP_DIV, 3'h0, 1'b0, 1'b0, 1'b1, 16'h1234, 16'h0000);
    `CHK({memWrite, resultData}, 17'h1ffff)
    apb(1'b0, `CAM_ADDR_DIV_REM, 32'h0);
    `CHK(rd, 32'h1234)
    $display("t_div done");
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard, far above the roughly 150 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end

  initial begin
    {sys_rst, clkEn, psel, penable, pwrite, trapLevelSet, trapLevelClear} = 7'b1100000;
    {paddr, pwdata} = '0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_level;
    t_arith;
    t_mul;
    t_div;
    report_and_stop;
  end
endmodule

bind cam_top cam_checker #(.DATA_W(DATA_W)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .opValid(opValid), .opCode(opCode),
  .byteMode(byteMode), .dstToMem(dstToMem), .trapLevelSet(trapLevelSet),
  .trapLevelClear(trapLevelClear), .resultData(resultData), .wregWrite(wregWrite),
  .memWrite(memWrite), .busy(busy), .processor_status_word(processor_status_word),
  .priority_level_top_bit(priority_level_top_bit),
  .program_space_window_enable(program_space_window_enable),
  .userIntBlock(userIntBlock));
